// file: design/cswu_defines.svh
// register offsets, field positions, reset values and timing for the chip-select unit
`ifndef CSWU_DEFINES_SVH
`define CSWU_DEFINES_SVH
`define CSWU_OFS_UPPER    8'HA0
`define CSWU_OFS_LOWER    8'HA2
`define CSWU_OFS_PERIPH   8'HA4
`define CSWU_OFS_MID      8'HA6
`define CSWU_OFS_AUX      8'HA8
`define CSWU_RST_UPPER    16'HF03B
`define CSWU_ONES_UPPER   16'H8030
`define CSWU_ONES_LOWER   16'H0F38
`define CSWU_ONES_PERIPH  16'H0000
`define CSWU_ONES_MID     16'H01F8
`define CSWU_ONES_AUX     16'H0000
`define CSWU_WM_UPPER     16'H708F
`define CSWU_WM_LOWER     16'H70C7
`define CSWU_WM_PERIPH    16'HFF8F
`define CSWU_WM_MID       16'HFE07
`define CSWU_WM_AUX       16'H7FC7
`define CSWU_B_SIZE_HI    14
`define CSWU_B_SIZE_LO    12
`define CSWU_B_DA         7
`define CSWU_B_PSE        6
`define CSWU_B_EX         7
`define CSWU_B_MS         6
`define CSWU_B_R3         3
`define CSWU_B_R2         2
`define CSWU_B_R1         1
`define CSWU_B_R0         0
`define CSWU_B_MID_BA_HI  15
`define CSWU_B_MID_BA_LO  9
`define CSWU_B_MSZ_HI     14
`define CSWU_B_MSZ_LO     8
`define CSWU_B_PBA_HI     15
`define CSWU_B_PBA_LO     7
`define CSWU_PCS_IDX_HI   10
`define CSWU_PCS_IDX_LO   8
`define CSWU_WS_C4        4'H5
`define CSWU_WS_C5        4'H7
`define CSWU_WS_C6        4'H9
`define CSWU_WS_C7        4'HF
`define CSWU_WS_RESET     4'H3
`define CSWU_STRAP_CAP    2'H2
`endif

// file: design/cswu_pkg.sv
// types shared by the chip-select and wait-state unit
package cswu_pkg;
  typedef logic [19:0] cswu_addr_t;
  typedef logic [15:0] cswu_word_t;
  typedef enum logic [2:0] {
    CSWU_IDLE  = 3'H1,
    CSWU_WAITS = 3'H2,
    CSWU_READY = 3'H4
  } cswu_state_e;
  typedef struct packed {
    cswu_word_t  upper;
    cswu_word_t  lower;
    cswu_word_t  periph;
    cswu_word_t  mid;
    cswu_word_t  aux;
    logic        upper_dflt;
    logic        lower_on;
    logic        seen_mid;
    logic        seen_aux;
    logic [1:0]  strap_cnt;
    logic        strap;
    cswu_word_t  rdata;
    cswu_state_e st;
    logic [3:0]  wcnt;
    logic        ign;
    logic        ucs_n;
    logic        lcs_n;
    logic [3:0]  mcs_n;
    logic [3:0]  pcs_n;
    logic [1:0]  pcs56_n;
    logic        pin6;
    logic        pin5;
    logic        apo;
    logic        psram;
    logic        async_ready_in_s1;
    logic        async_ready_in_s2;
    logic        sync_ready_in_s1;
    logic        sync_ready_in_s2;
    logic        strap_s1;
    logic        strap_s2;
  } cswu_regs_s;
endpackage : cswu_pkg

// file: design/cswu_top.sv
// chip-select decoder and wait-state generator for the multiplexed system bus
// Operation
// - upper select size from upper_region_size
// - strap high lets addr_phase_off drop upper address
// - ready_ignore skips external ready per region
// - upper waits 0,1,2,3,5,7,9,15 by code
// - lower select idle until its register touched
// - lower select size from lower_region_size
// - lower addr_phase_off drops address phase
// - psram_support_on marks lower cycles as psram
// - lower waits 0 to 3 by code
// - midrange idle until both registers touched
// - midrange base from register bits 15-9
// - four midrange selects split block in quarters
// - periph_pin_role picks selects or address pins
// - space_kind_sel picks memory or io cycles
// - periph selects 5,6 waits 0 to 3
// - periph base from register bits 15-7
// - periph selects 0-3 use eight-step wait table
// - midrange waits by its two-bit code
// - after reset upper on, top 64k, three waits
//
// Chosen here: the strobed register port.
`include "cswu_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module cswu_top (
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic               i_ce,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [15:0]        i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [15:0]        o_reg_rdata,
  input  wire logic               i_cyc_start,
  input  wire cswu_pkg::cswu_addr_t i_cyc_addr,
  input  wire logic               i_cyc_io,
  output logic                    o_cyc_done,
  output logic                    o_cyc_busy,
  input  wire logic               i_async_ready_in,
  input  wire logic               i_sync_ready_in,
  input  wire logic               i_byte_high_strap,
  output logic                    o_upper_mem_select_n,
  output logic                    o_lower_mem_select_n,
  output logic      [3:0]         o_mid_mem_select_n,
  output logic      [3:0]         o_periph_select_n,
  output logic                    o_pin_pcs6_a2,
  output logic                    o_pin_pcs5_a1,
  output logic                    o_addr_phase_off,
  output logic                    o_psram_cycle
);
  import cswu_pkg::*;

  cswu_regs_s s_reg;
  cswu_regs_s s_next;
  logic       ext_ready;
  logic       m_upper;
  logic       m_lower;
  logic       m_mid;
  logic       m_periph;
  logic       mid_on;
  logic [2:0] pidx;
  cswu_addr_t mid_base;
  cswu_addr_t mid_size;
  cswu_addr_t per_base;

  // eight-step wait table shared by upper and periph selects 0-3
  function automatic logic [3:0] wait_of(input logic [2:0] code);
    logic [3:0] w;
    w = {1'b0, code};
    unique case (code)
      3'H4:    w = `CSWU_WS_C4;
      3'H5:    w = `CSWU_WS_C5;
      3'H6:    w = `CSWU_WS_C6;
      3'H7:    w = `CSWU_WS_C7;
      default: w = {1'b0, code};
    endcase
    return w;
  endfunction : wait_of

  // quarter of the midrange block: the two bits just under the block size
  function automatic logic [1:0] mid_quarter(input logic [6:0] sz, input cswu_addr_t a);
    logic [1:0] q;
    q = 2'H0;
    for (int k = 0; k < 7; k++)
    begin
      if (sz[k])
        q = a[k + 10 -: 2];
    end
    return q;
  endfunction : mid_quarter

  // both ready pins must be high; either low stretches the cycle
  assign ext_ready = s_reg.async_ready_in_s2 & s_reg.sync_ready_in_s2;

  // address decode of the cycle being offered
  always_comb
  begin
    mid_on   = s_reg.seen_mid & s_reg.seen_aux;
    mid_base = {s_reg.mid[`CSWU_B_MID_BA_HI:`CSWU_B_MID_BA_LO], 13'H0000};
    mid_size = {2'H0, s_reg.aux[`CSWU_B_MSZ_HI:`CSWU_B_MSZ_LO], 11'H000};
    per_base = {s_reg.periph[`CSWU_B_PBA_HI:`CSWU_B_PBA_LO], 11'H000};
    pidx     = i_cyc_addr[`CSWU_PCS_IDX_HI:`CSWU_PCS_IDX_LO];
    // the upper block always ends at the top of memory
    m_upper  = !i_cyc_io &&
               (&(i_cyc_addr[19:16] | ~{1'b1, s_reg.upper[`CSWU_B_SIZE_HI:`CSWU_B_SIZE_LO]}));
    // the lower block always starts at zero
    m_lower  = !i_cyc_io && s_reg.lower_on &&
               !(|(i_cyc_addr[19:16] & ~{1'b0, s_reg.lower[`CSWU_B_SIZE_HI:`CSWU_B_SIZE_LO]}));
    m_mid    = !i_cyc_io && mid_on && (mid_size != 20'H00000) &&
               (((i_cyc_addr ^ mid_base) & ~(mid_size - 20'H00001)) == 20'H00000);
    // periph selects answer memory or io cycles as chosen; slots 4 and 7 have no pin
    m_periph = (i_cyc_io != s_reg.aux[`CSWU_B_MS]) && (pidx != 3'H4) && (pidx != 3'H7) &&
               (i_cyc_addr[19:11] == per_base[19:11]);
  end

  // one next-state process; registers, strap capture and the cycle sequencer
  always_comb
  begin
    s_next          = s_reg;
    s_next.async_ready_in_s1  = i_async_ready_in;
    s_next.async_ready_in_s2  = s_reg.async_ready_in_s1;
    s_next.sync_ready_in_s1  = i_sync_ready_in;
    s_next.sync_ready_in_s2  = s_reg.sync_ready_in_s1;
    s_next.strap_s1 = i_byte_high_strap;
    s_next.strap_s2 = s_reg.strap_s1;
    o_cyc_done      = 1'b0;
    // the strap is taken once the synchroniser has filled after reset
    if (s_reg.strap_cnt != 2'H3)
      s_next.strap_cnt = s_reg.strap_cnt + 2'H1;
    if (s_reg.strap_cnt == `CSWU_STRAP_CAP)
      s_next.strap = s_reg.strap_s2;
    // register writes; read-only bits keep their fixed pattern
    if (i_reg_wr)
    begin
      unique case (i_reg_addr)
        `CSWU_OFS_UPPER:  s_next.upper  = (i_reg_wdata & `CSWU_WM_UPPER) | `CSWU_ONES_UPPER;
        `CSWU_OFS_LOWER:  s_next.lower  = (i_reg_wdata & `CSWU_WM_LOWER) | `CSWU_ONES_LOWER;
        `CSWU_OFS_PERIPH: s_next.periph = (i_reg_wdata & `CSWU_WM_PERIPH) | `CSWU_ONES_PERIPH;
        `CSWU_OFS_MID:    s_next.mid    = (i_reg_wdata & `CSWU_WM_MID) | `CSWU_ONES_MID;
        `CSWU_OFS_AUX:    s_next.aux    = (i_reg_wdata & `CSWU_WM_AUX) | `CSWU_ONES_AUX;
        default:          s_next.rdata  = s_reg.rdata;
      endcase
    end
    // the boot-time three waits last until software first programs the upper register
    if (i_reg_wr && (i_reg_addr == `CSWU_OFS_UPPER))
      s_next.upper_dflt = 1'b0;
    // any touch, read or write, arms the lower and midrange selects
    if (i_reg_wr || i_reg_rd)
    begin
      if (i_reg_addr == `CSWU_OFS_LOWER)
        s_next.lower_on = 1'b1;
      if (i_reg_addr == `CSWU_OFS_MID)
        s_next.seen_mid = 1'b1;
      if (i_reg_addr == `CSWU_OFS_AUX)
        s_next.seen_aux = 1'b1;
    end
    // read data stands for one cycle only; unmapped reads give zero
    s_next.rdata = 16'H0000;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        `CSWU_OFS_UPPER:  s_next.rdata = s_reg.upper;
        `CSWU_OFS_LOWER:  s_next.rdata = s_reg.lower;
        `CSWU_OFS_PERIPH: s_next.rdata = s_reg.periph;
        `CSWU_OFS_MID:    s_next.rdata = s_reg.mid;
        `CSWU_OFS_AUX:    s_next.rdata = s_reg.aux;
        default:          s_next.rdata = 16'H0000;
      endcase
    end
    // cycle sequencer: count programmed waits, then wait for ready
    unique case (s_reg.st)
      CSWU_IDLE:
      begin
        if (i_cyc_start)
        begin
          // in select role the shared pins idle high and never carry address
          s_next.pin6 = s_reg.aux[`CSWU_B_EX] | i_cyc_addr[2];
          s_next.pin5 = s_reg.aux[`CSWU_B_EX] | i_cyc_addr[1];
          s_next.wcnt = 4'H0;
          s_next.ign  = 1'b0;
          // priority upper, lower, midrange, periph; overlaps are a software fault
          if (m_upper)
          begin
            s_next.ucs_n = 1'b0;
            s_next.wcnt  = s_reg.upper_dflt ? `CSWU_WS_RESET :
                           wait_of({s_reg.upper[`CSWU_B_R3], s_reg.upper[`CSWU_B_R1:`CSWU_B_R0]});
            s_next.ign   = s_reg.upper[`CSWU_B_R2];
            s_next.apo   = s_reg.strap & s_reg.upper[`CSWU_B_DA];
          end
          else if (m_lower)
          begin
            s_next.lcs_n = 1'b0;
            s_next.wcnt  = {2'H0, s_reg.lower[`CSWU_B_R1:`CSWU_B_R0]};
            s_next.ign   = s_reg.lower[`CSWU_B_R2];
            s_next.apo   = s_reg.lower[`CSWU_B_DA];
            s_next.psram = s_reg.lower[`CSWU_B_PSE];
          end
          else if (m_mid)
          begin
            s_next.mcs_n[mid_quarter(s_reg.aux[`CSWU_B_MSZ_HI:`CSWU_B_MSZ_LO], i_cyc_addr)] = 1'b0;
            s_next.wcnt  = {2'H0, s_reg.mid[`CSWU_B_R1:`CSWU_B_R0]};
            s_next.ign   = s_reg.mid[`CSWU_B_R2];
          end
          else if (m_periph && !pidx[2])
          begin
            s_next.pcs_n[pidx[1:0]] = 1'b0;
            s_next.wcnt  = wait_of({s_reg.periph[`CSWU_B_R3], s_reg.periph[`CSWU_B_R1:`CSWU_B_R0]});
            s_next.ign   = s_reg.periph[`CSWU_B_R2];
          end
          else if (m_periph)
          begin
            s_next.pcs56_n[pidx[1]] = 1'b0;
            // shared pins show the select only in select role
            if (s_reg.aux[`CSWU_B_EX])
            begin
              s_next.pin6 = ~pidx[1];
              s_next.pin5 = pidx[1];
            end
            s_next.wcnt  = {2'H0, s_reg.aux[`CSWU_B_R1:`CSWU_B_R0]};
            s_next.ign   = s_reg.aux[`CSWU_B_R2];
          end
          s_next.st = CSWU_WAITS;
        end
      end
      CSWU_WAITS:
      begin
        if (s_reg.wcnt == 4'H0)
          s_next.st = CSWU_READY;
        else
          s_next.wcnt = s_reg.wcnt - 4'H1;
      end
      CSWU_READY:
      begin
        // ready is only honoured after the programmed waits have run out
        if (s_reg.ign || ext_ready)
        begin
          o_cyc_done     = 1'b1;
          s_next.st      = CSWU_IDLE;
          s_next.ucs_n   = 1'b1;
          s_next.lcs_n   = 1'b1;
          s_next.mcs_n   = 4'HF;
          s_next.pcs_n   = 4'HF;
          s_next.pcs56_n = 2'H3;
          s_next.apo     = 1'b0;
          s_next.psram   = 1'b0;
          s_next.pin6    = ~s_reg.aux[`CSWU_B_EX] & s_reg.pin6;
          s_next.pin5    = ~s_reg.aux[`CSWU_B_EX] & s_reg.pin5;
          if (s_reg.aux[`CSWU_B_EX])
          begin
            s_next.pin6 = 1'b1;
            s_next.pin5 = 1'b1;
          end
        end
      end
      default: s_next.st = CSWU_IDLE;
    endcase
    // reset: upper on over top 64k with three waits, lower and midrange unarmed
    if (i_reset)
    begin
      s_next         = '0;
      s_next.upper   = `CSWU_RST_UPPER;
      s_next.upper_dflt = 1'b1;
      s_next.lower   = `CSWU_ONES_LOWER;
      s_next.periph  = `CSWU_ONES_PERIPH;
      s_next.mid     = `CSWU_ONES_MID;
      s_next.aux     = `CSWU_ONES_AUX;
      s_next.st      = CSWU_IDLE;
      s_next.ucs_n   = 1'b1;
      s_next.lcs_n   = 1'b1;
      s_next.mcs_n   = 4'HF;
      s_next.pcs_n   = 4'HF;
      s_next.pcs56_n = 2'H3;
      s_next.async_ready_in_s1 = 1'b1;
      s_next.async_ready_in_s2 = 1'b1;
      s_next.sync_ready_in_s1 = 1'b1;
      s_next.sync_ready_in_s2 = 1'b1;
    end
    if (!i_ce)
      o_cyc_done = 1'b0;
  end

  // the clock enable freezes everything except reset
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset || i_ce)
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign o_reg_rdata          = s_reg.rdata;
  assign o_cyc_busy           = (s_reg.st != CSWU_IDLE);
  assign o_upper_mem_select_n = s_reg.ucs_n;
  assign o_lower_mem_select_n = s_reg.lcs_n;
  assign o_mid_mem_select_n   = s_reg.mcs_n;
  assign o_periph_select_n    = s_reg.pcs_n;
  assign o_pin_pcs6_a2        = s_reg.pin6;
  assign o_pin_pcs5_a1        = s_reg.pin5;
  assign o_addr_phase_off     = s_reg.apo;
  assign o_psram_cycle        = s_reg.psram;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  upper_reset_val_a: assert property ($fell(i_reset) |-> s_reg.upper == `CSWU_RST_UPPER)
    else $error("upper register not at reset value");
  lower_gate_a: assert property (!s_reg.lower_on |-> o_lower_mem_select_n)
    else $error("lower select active before arming");
  mid_gate_a: assert property (!(s_reg.seen_mid && s_reg.seen_aux) |-> &o_mid_mem_select_n)
    else $error("midrange select active before arming");
  one_select_a: assert property ($countones(~{o_upper_mem_select_n, o_lower_mem_select_n, o_mid_mem_select_n,
                                             o_periph_select_n, s_reg.pcs56_n}) <= 1)
    else $error("more than one select low");
  wait_count_a: assert property ((i_ce && s_reg.st == CSWU_WAITS && s_reg.wcnt != 4'H0)
                                 |=> s_reg.wcnt == $past(s_reg.wcnt) - 4'H1)
    else $error("wait counter did not step");
  ready_hold_a: assert property ((s_reg.st == CSWU_READY && !s_reg.ign && !ext_ready) |-> !o_cyc_done)
    else $error("cycle ended without ready");
  pin_addr_a: assert property ((i_ce && s_reg.st == CSWU_IDLE && i_cyc_start && !s_reg.aux[`CSWU_B_EX])
                               |=> o_pin_pcs6_a2 == $past(i_cyc_addr[2]) && o_pin_pcs5_a1 == $past(i_cyc_addr[1]))
    else $error("shared pins do not carry address");
  addr_phase_a: assert property (o_addr_phase_off |->
                                 (!o_upper_mem_select_n && s_reg.strap) || !o_lower_mem_select_n)
    else $error("address phase dropped outside upper or lower cycle");
  psram_cycle_a: assert property (o_psram_cycle |-> !o_lower_mem_select_n && s_reg.lower[`CSWU_B_PSE])
    else $error("psram flag outside lower psram cycle");
endmodule : cswu_top
`default_nettype wire

// file: verification/cswu_mem_model.sv
// far-side memory and peripheral chips: stretch the cycle through the ready lines
`timescale 1ns/1ns
`default_nettype none
module cswu_mem_model (
  input  wire logic       i_ref_clk,
  input  wire logic [9:0] i_sel_n,
  input  wire logic [3:0] i_stall,
  output logic            o_async_ready,
  output logic            o_sync_ready
);
  logic [3:0] held_reg = 4'H0;

  // count cycles since a chip was selected, saturating so a long cycle cannot wrap
  always_ff @(posedge i_ref_clk)
  begin
    if (&i_sel_n)
      held_reg <= 4'H0;
    else if (held_reg != 4'HF)
      held_reg <= held_reg + 4'H1;
  end

  // a selected slow chip pulls ready low until its access time is over; the pull-up wins otherwise
  assign o_async_ready = (&i_sel_n) || (held_reg >= i_stall);
  assign o_sync_ready  = 1'H1;  // pull-up only, the async line carries every stall
endmodule : cswu_mem_model
`default_nettype wire

// file: verification/cswu_top_tb.sv
// self-checking bench for the chip-select and wait-state unit
`timescale 1ns/1ns
`default_nettype none
module cswu_top_tb;
  import cswu_pkg::*;
  typedef struct packed {cswu_addr_t a; logic io; logic [11:0] s; logic [3:0] w; logic [1:0] f;} cswu_row_s;
  typedef struct packed {logic [7:0] a; cswu_word_t d; cswu_word_t rb;} cswu_reg_s;
  logic       clk = 1'H0, rst = 1'H1, wr = 1'H0, rd = 1'H0, start = 1'H0, io = 1'H0, strap = 1'H0;
  logic [7:0] ra = 8'H0;
  cswu_word_t wd = 16'H0, rdata;
  cswu_addr_t ca = 20'H0;
  logic       done, busy, upper_mem_select, lower_mem_select, p6, p5, apo, ps, async_ready_in, sync_ready_in;
  logic [3:0] mid_mem_select, periph_select, stall = 4'H0;
  int         fail_count = 0, comparisons = 0, n;
  cswu_reg_s  regs [6] = '{
    '{8'HA0, 16'H608C, 16'HE0BC},
    '{8'HA2, 16'H10C6, 16'H1FFE},
    '{8'HA4, 16'H400D, 16'H400D},
    '{8'HA6, 16'H8005, 16'H81FD},
    '{8'HA8, 16'H04C7, 16'H04C7},
    '{8'HAA, 16'H1234, 16'H0000}};
  cswu_row_s  rows [14] = '{
    '{20'HE0000, 1'H0, 12'H7FF, 4'H5, 2'H0},
    '{20'HDFFFF, 1'H0, 12'HFFF, 4'H0, 2'H0},
    '{20'H1FFFF, 1'H0, 12'HBFF, 4'H2, 2'H3},
    '{20'H20000, 1'H0, 12'HFFF, 4'H0, 2'H0},
    '{20'H80000, 1'H0, 12'HFBF, 4'H1, 2'H0},
    '{20'H817FF, 1'H0, 12'HEFF, 4'H1, 2'H0},
    '{20'H81800, 1'H0, 12'HDFF, 4'H1, 2'H0},
    '{20'H82000, 1'H0, 12'HFFF, 4'H0, 2'H0},
    '{20'H40000, 1'H0, 12'HFFB, 4'H7, 2'H0},
    '{20'H40300, 1'H0, 12'HFDF, 4'H7, 2'H0},
    '{20'H40500, 1'H0, 12'HFFE, 4'H3, 2'H0},
    '{20'H40600, 1'H0, 12'HFFD, 4'H3, 2'H0},
    '{20'H40400, 1'H0, 12'HFFF, 4'H0, 2'H0},
    '{20'H40000, 1'H1, 12'HFFF, 4'H0, 2'H0}};

  cswu_top dut_u (.i_ref_clk(clk), .i_reset(rst), .i_ce(1'H1), .i_reg_addr(ra), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cyc_start(start), .i_cyc_addr(ca),
    .i_cyc_io(io), .o_cyc_done(done), .o_cyc_busy(busy), .i_async_ready_in(async_ready_in),
    .i_sync_ready_in(sync_ready_in), .i_byte_high_strap(strap), .o_upper_mem_select_n(upper_mem_select),
    .o_lower_mem_select_n(lower_mem_select), .o_mid_mem_select_n(mid_mem_select), .o_periph_select_n(periph_select),
    .o_pin_pcs6_a2(p6), .o_pin_pcs5_a1(p5), .o_addr_phase_off(apo), .o_psram_cycle(ps));
  cswu_mem_model mem_u (.i_ref_clk(clk), .i_sel_n({upper_mem_select, lower_mem_select, mid_mem_select, periph_select}), .i_stall(stall),
    .o_async_ready(async_ready_in), .o_sync_ready(sync_ready_in));

  // 20 MHz reference clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task do_reset(input logic s);
    strap <= s;
    rst   <= 1'H1;
    repeat (16) @(posedge clk);
    rst <= 1'H0;
  endtask : do_reset

  task wreg(input logic [7:0] a, input cswu_word_t d);
    @(posedge clk);
    ra <= a;
    wd <= d;
    wr <= 1'H1;
    @(posedge clk);
    wr <= 1'H0;
  endtask : wreg

  task rreg(input logic [7:0] a, input cswu_word_t e);
    @(posedge clk);
    ra <= a;
    rd <= 1'H1;
    @(posedge clk);
    rd <= 1'H0;
    #1 check(rdata, e);
  endtask : rreg

  // one bus cycle: selects and flags right after the take edge, then edges until done
  task cyc(input cswu_row_s r);
    @(posedge clk);
    start <= 1'H1;
    ca    <= r.a;
    io    <= r.io;
    @(posedge clk);
    start <= 1'H0;
    #1 check({upper_mem_select, lower_mem_select, mid_mem_select, periph_select, p6, p5}, r.s);
    check({apo, ps}, r.f);
    n = 0;
    while (done !== 1'H1 && n < 60)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 60)
    begin
      fail_count++;
      end_of_test();
    end
    if (stall == 4'H0)
      check(n, r.w + 1);
    @(posedge clk);
    #1 check({upper_mem_select, lower_mem_select, mid_mem_select, periph_select, busy}, 11'H7FE);
  endtask : cyc

  initial
  begin
    do_reset(1'H0);
    cyc('{20'HFFFF0, 1'H0, 12'H7FC, 4'H3, 2'H0});
    cyc('{20'HEFFFF, 1'H0, 12'HFFF, 4'H0, 2'H0});
    cyc('{20'H00000, 1'H0, 12'HFFC, 4'H0, 2'H0});
    rreg(8'HA0, 16'HF03B);
    $display("reset state test done");
    foreach (regs[i])
    begin
      wreg(regs[i].a, regs[i].d);
      rreg(regs[i].a, regs[i].rb);
    end
    foreach (rows[i])
      cyc(rows[i]);
    $display("region table test done");
    stall <= 4'H4;
    cyc(rows[0]);
    check(n, 6);
    wreg(8'HA2, 16'H1002);
    cyc('{20'H00000, 1'H0, 12'HBFF, 4'H2, 2'H0});
    check(n > 3, 1'H1);
    stall <= 4'H0;
    $display("ready stall test done");
    wreg(8'HA8, 16'H0407);
    wreg(8'HA4, 16'H008D);
    cyc('{20'H00906, 1'H1, 12'HFF7, 4'H7, 2'H0});
    $display("io space test done");
    do_reset(1'H1);
    wreg(8'HA0, 16'HF084);
    cyc('{20'HFFFF0, 1'H0, 12'H7FC, 4'H0, 2'H2});
    rreg(8'HA2, 16'H0F38);
    cyc('{20'H00000, 1'H0, 12'HBFC, 4'H0, 2'H0});
    wreg(8'HA6, 16'H8005);
    cyc('{20'H80000, 1'H0, 12'HFFC, 4'H0, 2'H0});
    rreg(8'HA8, 16'H0000);
    cyc('{20'H80000, 1'H0, 12'HFFC, 4'H0, 2'H0});
    wreg(8'HA8, 16'H0400);
    cyc('{20'H80000, 1'H0, 12'HFBC, 4'H1, 2'H0});
    $display("second reset test done");
    end_of_test();
  end
endmodule : cswu_top_tb
`default_nettype wire
